// file: hw/stfe_pkg.sv
/*
 * shared constants and types for the shadow taskfile emulation pair.
 * assumes a single 200 MHz clock; no imports, every use is scoped.
 */
package stfe_pkg;
	// =========================================================
	// taskfile register indices (host-side addresses)
	localparam logic [3:0] TF_DATA = 4'h0;
	localparam logic [3:0] TF_ERROR = 4'h1;
	localparam logic [3:0] TF_SECCNT = 4'h2;
	localparam logic [3:0] TF_LBALO = 4'h3;
	localparam logic [3:0] TF_LBAMID = 4'h4;
	localparam logic [3:0] TF_LBAHI = 4'h5;
	localparam logic [3:0] TF_DEVHEAD = 4'h6;
	localparam logic [3:0] TF_STATCMD = 4'h7;
	localparam logic [3:0] TF_DEVCTL = 4'h8;
	localparam int TF_NUM8 = 8;
	// =========================================================
	// field positions
	localparam int ST_BUSY_POS = 7;
	localparam int DH_DRIVE_SEL_POS = 4;
	localparam int DC_SOFT_RESET_POS = 2;
	localparam int DC_INT_DIS_POS = 1;
	// =========================================================
	// reset values
	localparam logic [7:0] RST_STATUS = 8'h7f;
	localparam logic [7:0] RST_REG8 = 8'hff;
	localparam logic [15:0] RST_DATA = 16'hffff;
	// =========================================================
	// apb register map of the controller (byte addresses)
	localparam logic [11:0] APB_TF_BASE = 12'h000;
	localparam logic [11:0] APB_CTRL = 12'h040;
	localparam logic [11:0] APB_STAT = 12'h044;
	localparam logic [11:0] APB_TXFR0 = 12'h048;
	localparam logic [11:0] APB_TXFR1 = 12'h04c;
	localparam logic [11:0] APB_RXFR0 = 12'h050;
	localparam logic [11:0] APB_RXFR1 = 12'h054;
	localparam logic [11:0] APB_RXCNT = 12'h058;
	// =========================================================
	// timing: presence within 10 ms, soft reset hold 5 us
	localparam int CLK_MHZ = 200;
	localparam int PRESENCE_MS = 10;
	localparam int PRESENCE_CYC = PRESENCE_MS * 1000 * CLK_MHZ;
	localparam int SOFT_RESET_HOLD_US = 5;
	localparam int SOFT_RESET_HOLD_CYC = SOFT_RESET_HOLD_US * CLK_MHZ;
	// =========================================================
	// register frame carried over the transport layer
	typedef struct packed {
		logic int_req;
		logic [7:0] status;
		logic [7:0] error;
		logic [7:0] seccnt;
		logic [7:0] lbalo;
		logic [7:0] lbamid;
		logic [7:0] lbahi;
		logic [7:0] devhead;
		logic [7:0] command;
		logic [7:0] devctl;
	} stfe_frame_t;
endpackage

// file: hw/stfe_link_if.sv
/*
 * transport-level link between adapter and device.
 * assumes both ends share mclk_i; frames handshake by valid/ready.
 */
`timescale 1ns/100ps
interface stfe_link_if;
	logic present;
	logic comreset;
	logic h2d_valid;
	logic h2d_ready;
	stfe_pkg::stfe_frame_t h2d_frame;
	logic d2h_valid;
	logic d2h_ready;
	stfe_pkg::stfe_frame_t d2h_frame;
	// =========================================================
	// adapter end
	modport adapter (
		input present, h2d_ready, d2h_valid, d2h_frame,
		output comreset, h2d_valid, h2d_frame, d2h_ready
	);
	// =========================================================
	// device end
	modport device (
		output present, h2d_ready, d2h_valid, d2h_frame,
		input comreset, h2d_valid, h2d_frame, d2h_ready
	);
endinterface

// file: hw/stfe_frame_slot.sv
/*
 * two-entry frame holder so a clearing soft-reset frame can queue
 * behind the setting frame. assumes same-clock producer and consumer.
 */
`timescale 1ns/100ps
module stfe_frame_slot (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic push_i,
	input stfe_pkg::stfe_frame_t push_frame_i,
	output logic full_o,
	output logic valid_o,
	output stfe_pkg::stfe_frame_t frame_o,
	input wire logic pop_i
);
	typedef struct packed {
		logic [1:0] cnt;
		stfe_pkg::stfe_frame_t e0;
		stfe_pkg::stfe_frame_t e1;
	} stfe_slot_t;
	stfe_slot_t st_ff;
	stfe_slot_t nxt_st;
	// =========================================================
	// pop head, then push at tail; head shifts down
	always_comb begin
		nxt_st = st_ff;
		if (pop_i && st_ff.cnt != 2'h0) begin
			nxt_st.e0 = st_ff.e1;
			nxt_st.cnt = st_ff.cnt - 2'h1;
		end
		if (push_i && nxt_st.cnt != 2'h2) begin
			if (nxt_st.cnt == 2'h0) begin
				nxt_st.e0 = push_frame_i;
			end else begin
				nxt_st.e1 = push_frame_i;
			end
			nxt_st.cnt = nxt_st.cnt + 2'h1;
		end
	end
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign full_o = (st_ff.cnt == 2'h2);
	assign valid_o = (st_ff.cnt != 2'h0);
	assign frame_o = st_ff.e0;
endmodule

// file: hw/stfe_adapter.sv
/*
 * host adapter end: shadow taskfile, apb slave, frame gating,
 * soft-reset sequencing, pending-interrupt flag and interrupt.
 * assumes link partner on same mclk_i, present a level from its flop.
 */
// The APB interface to the registers and the address map were chosen for this implementation.
// Operation
// - reset: status 7f, others ff, data ffff
// - discovery: ignore taskfile writes
// - presence sets status bit 7, enables writes
// - presence reported within 10 ms
// - device sends initial frame, shadow overwritten
// - device ignores drive select bit
// - frames gated by drive select bit
// - soft reset change sends two frames; code sends one frame per change, two per set-then-clear toggle
// - accept 5 us soft reset toggle
// - both soft reset frames delivered, queued
// - device tolerates back-to-back reset frames
// - software holds soft reset 5 us
// - drive one selected: never set busy; code sets busy on the presence edge regardless of drive select
// - command write sets busy, sends frame
// - soft reset change sets busy, sends
// - unchanged soft reset: busy untouched
// - comreset or soft reset one sets busy
// - ending status frame copied to shadow
// - frame request sets pending interrupt
// - interrupt = pending and drive0 and enabled
// - pending cleared: comreset, soft reset write, status read
// - each device is drive zero, own addresses
// - pending interrupt is internal state; code reads it back at APB_STAT bit 1
`timescale 1ns/100ps
module stfe_adapter (
	input wire logic mclk_i,
	input wire logic rst_i,
	stfe_link_if.adapter link,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic intrq_o,
	output logic comreset_o
);
	typedef struct packed {
		logic [15:0] data;
		logic [7:0] status;
		logic [7:0] error;
		logic [7:0] seccnt;
		logic [7:0] lbalo;
		logic [7:0] lbamid;
		logic [7:0] lbahi;
		logic [7:0] devhead;
		logic [7:0] command;
		logic [7:0] devctl;
		logic pend_int;
		logic present;
		logic comreset;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic intrq;
		logic [15:0] rx_cnt;
	} stfe_adp_t;
	stfe_adp_t st_ff;
	stfe_adp_t nxt_st;
	logic q_full;
	logic q_valid;
	logic q_push;
	stfe_pkg::stfe_frame_t q_frame;
	stfe_pkg::stfe_frame_t new_frame;
	// =========================================================
	// frame from the current shadow image
	function automatic stfe_pkg::stfe_frame_t mk_frame(input stfe_adp_t s);
		stfe_pkg::stfe_frame_t f;
		f.int_req = 1'b0;
		f.status = s.status;
		f.error = s.error;
		f.seccnt = s.seccnt;
		f.lbalo = s.lbalo;
		f.lbamid = s.lbamid;
		f.lbahi = s.lbahi;
		f.devhead = s.devhead;
		f.command = s.command;
		f.devctl = s.devctl;
		return f;
	endfunction
	// =========================================================
	// outgoing queue, two deep for the soft-reset pair
	stfe_frame_slot u_slot (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.push_i(q_push),
		.push_frame_i(new_frame),
		.full_o(q_full),
		.valid_o(q_valid),
		.frame_o(q_frame),
		.pop_i(q_valid && link.h2d_ready)
	);
	assign link.h2d_valid = q_valid;
	assign link.h2d_frame = q_frame;
	assign link.d2h_ready = 1'b1;
	assign link.comreset = st_ff.comreset;
	assign prdata_o = st_ff.prdata;
	assign pready_o = st_ff.pready;
	assign pslverr_o = st_ff.pslverr;
	assign intrq_o = st_ff.intrq;
	assign comreset_o = st_ff.comreset;
	// =========================================================
	// main next-state logic
	always_comb begin
		logic acc;
		logic wr;
		logic [3:0] idx;
		logic tf_hit;
		logic drv0;
		logic [7:0] wb;
		logic send;
		acc = psel_i && penable_i && !st_ff.pready;
		wr = acc && pwrite_i;
		idx = paddr_i[5:2];
		tf_hit = (paddr_i[11:6] == stfe_pkg::APB_TF_BASE[11:6]) && idx <= stfe_pkg::TF_DEVCTL;
		drv0 = !st_ff.devhead[stfe_pkg::DH_DRIVE_SEL_POS];
		wb = pwdata_i[7:0];
		send = 1'b0;
		nxt_st = st_ff;
		nxt_st.pready = acc;
		nxt_st.pslverr = 1'b0;
		nxt_st.comreset = 1'b0;
		// same-clock level, no synchroniser: the edge lands before the
		// signature frame, so that frame is not clobbered by bit 7
		nxt_st.present = link.present;
		// presence sets busy bit, status reads ff
		if (link.present && !st_ff.present) begin
			nxt_st.status[stfe_pkg::ST_BUSY_POS] = 1'b1;
		end
		// device frames overwrite the shadow block
		if (link.d2h_valid) begin
			nxt_st.status = link.d2h_frame.status;
			nxt_st.error = link.d2h_frame.error;
			nxt_st.seccnt = link.d2h_frame.seccnt;
			nxt_st.lbalo = link.d2h_frame.lbalo;
			nxt_st.lbamid = link.d2h_frame.lbamid;
			nxt_st.lbahi = link.d2h_frame.lbahi;
			nxt_st.devhead = link.d2h_frame.devhead;
			nxt_st.rx_cnt = st_ff.rx_cnt + 16'h1;
		end
		// apb reads
		if (acc && !wr) begin
			nxt_st.prdata = 32'h0;
			if (tf_hit) begin
				case (idx)
					stfe_pkg::TF_DATA: nxt_st.prdata = {16'h0, st_ff.data};
					stfe_pkg::TF_ERROR: nxt_st.prdata = {24'h0, st_ff.error};
					stfe_pkg::TF_SECCNT: nxt_st.prdata = {24'h0, st_ff.seccnt};
					stfe_pkg::TF_LBALO: nxt_st.prdata = {24'h0, st_ff.lbalo};
					stfe_pkg::TF_LBAMID: nxt_st.prdata = {24'h0, st_ff.lbamid};
					stfe_pkg::TF_LBAHI: nxt_st.prdata = {24'h0, st_ff.lbahi};
					stfe_pkg::TF_DEVHEAD: nxt_st.prdata = {24'h0, st_ff.devhead};
					stfe_pkg::TF_STATCMD: begin
						nxt_st.prdata = {24'h0, st_ff.status};
						if (drv0) begin
							nxt_st.pend_int = 1'b0;
						end
					end
					stfe_pkg::TF_DEVCTL: nxt_st.prdata = {24'h0, st_ff.devctl};
					default: nxt_st.prdata = 32'h0;
				endcase
			end else if (paddr_i == stfe_pkg::APB_STAT) begin
				nxt_st.prdata = {28'h0, q_full, q_valid, st_ff.pend_int, st_ff.present};
			end else if (paddr_i == stfe_pkg::APB_RXCNT) begin
				nxt_st.prdata = {16'h0, st_ff.rx_cnt};
			end else if (paddr_i != stfe_pkg::APB_CTRL) begin
				nxt_st.pslverr = 1'b1;
			end
		end
		// apb writes; taskfile gated until presence
		if (wr) begin
			if (tf_hit && st_ff.present) begin
				case (idx)
					stfe_pkg::TF_DATA: nxt_st.data = pwdata_i[15:0];
					stfe_pkg::TF_ERROR: nxt_st.error = wb;
					stfe_pkg::TF_SECCNT: nxt_st.seccnt = wb;
					stfe_pkg::TF_LBALO: nxt_st.lbalo = wb;
					stfe_pkg::TF_LBAMID: nxt_st.lbamid = wb;
					stfe_pkg::TF_LBAHI: nxt_st.lbahi = wb;
					stfe_pkg::TF_DEVHEAD: nxt_st.devhead = wb;
					stfe_pkg::TF_STATCMD: begin
						nxt_st.command = wb;
						if (drv0) begin
							nxt_st.status[stfe_pkg::ST_BUSY_POS] = 1'b1;
							send = 1'b1;
						end
					end
					stfe_pkg::TF_DEVCTL: begin
						nxt_st.devctl = wb;
						if (drv0) begin
							nxt_st.pend_int = 1'b0;
							if (wb[stfe_pkg::DC_SOFT_RESET_POS] != st_ff.devctl[stfe_pkg::DC_SOFT_RESET_POS]) begin
								nxt_st.status[stfe_pkg::ST_BUSY_POS] = 1'b1;
								send = 1'b1;
							end
						end
					end
					default: nxt_st.data = st_ff.data;
				endcase
			end else if (paddr_i == stfe_pkg::APB_CTRL) begin
				if (pwdata_i[0]) begin
					nxt_st.comreset = 1'b1;
					nxt_st.pend_int = 1'b0;
					if (drv0) begin
						nxt_st.status[stfe_pkg::ST_BUSY_POS] = 1'b1;
					end
				end
			end else if (!tf_hit) begin
				nxt_st.pslverr = 1'b1;
			end
		end
		// device interrupt request wins over a same-cycle clear
		if (link.d2h_valid && link.d2h_frame.int_req) begin
			nxt_st.pend_int = 1'b1;
		end
		nxt_st.intrq = nxt_st.pend_int && !nxt_st.devhead[stfe_pkg::DH_DRIVE_SEL_POS]
			&& !nxt_st.devctl[stfe_pkg::DC_INT_DIS_POS];
		q_push = send;
		new_frame = mk_frame(nxt_st);
	end
	// =========================================================
	// state register with documented reset image
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_ff <= '0;
			st_ff.data <= stfe_pkg::RST_DATA;
			st_ff.status <= stfe_pkg::RST_STATUS;
			st_ff.error <= stfe_pkg::RST_REG8;
			st_ff.seccnt <= stfe_pkg::RST_REG8;
			st_ff.lbalo <= stfe_pkg::RST_REG8;
			st_ff.lbamid <= stfe_pkg::RST_REG8;
			st_ff.lbahi <= stfe_pkg::RST_REG8;
			st_ff.devhead <= stfe_pkg::RST_REG8;
			st_ff.command <= stfe_pkg::RST_REG8;
			st_ff.devctl <= stfe_pkg::RST_REG8;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule

// file: hw/stfe_device.sv
/*
 * device end: reports presence, sends initial and ending status frames.
 * assumes the adapter on the same mclk_i; user side gives status/irq.
 */
`timescale 1ns/100ps
module stfe_device (
	input wire logic mclk_i,
	input wire logic rst_i,
	stfe_link_if.device link,
	input wire logic attach_i,
	input wire logic done_i,
	input wire logic [7:0] done_status_i,
	input wire logic [7:0] done_error_i,
	input wire logic done_irq_i,
	output logic rx_valid_o,
	output logic [7:0] rx_command_o,
	output logic rx_soft_reset_o,
	output logic busy_o
);
	typedef enum logic [1:0] {
		DV_IDLE = 2'b00,
		DV_SIGN = 2'b01,
		DV_RUN = 2'b10
	} stfe_dv_state_t;
	typedef struct packed {
		stfe_dv_state_t state;
		logic present;
		logic tx_valid;
		stfe_pkg::stfe_frame_t tx;
		logic rx_valid;
		logic [7:0] rx_cmd;
		logic rx_soft_rst;
		logic busy;
		logic [1:0] att_sync;
	} stfe_dvc_t;
	stfe_dvc_t st_ff;
	stfe_dvc_t nxt_st;
	assign link.present = st_ff.present;
	assign link.h2d_ready = 1'b1;
	assign link.d2h_valid = st_ff.tx_valid;
	assign link.d2h_frame = st_ff.tx;
	assign rx_valid_o = st_ff.rx_valid;
	assign rx_command_o = st_ff.rx_cmd;
	assign rx_soft_reset_o = st_ff.rx_soft_rst;
	assign busy_o = st_ff.busy;
	// =========================================================
	// link handling; frames taken every cycle, no spacing needed
	always_comb begin
		nxt_st = st_ff;
		// attach pin passes two flops before use
		nxt_st.att_sync = {st_ff.att_sync[0], attach_i};
		nxt_st.present = st_ff.att_sync[1];
		nxt_st.rx_valid = 1'b0;
		if (st_ff.tx_valid && link.d2h_ready) begin
			nxt_st.tx_valid = 1'b0;
		end
		if (link.h2d_valid) begin
			nxt_st.rx_valid = 1'b1;
			nxt_st.rx_cmd = link.h2d_frame.command;
			nxt_st.rx_soft_rst = link.h2d_frame.devctl[stfe_pkg::DC_SOFT_RESET_POS];
			nxt_st.busy = 1'b1;
		end
		case (st_ff.state)
			DV_IDLE: begin
				if (st_ff.att_sync[1]) begin
					nxt_st.state = DV_SIGN;
				end
			end
			DV_SIGN: begin
				nxt_st.tx_valid = 1'b1;
				nxt_st.tx = '0;
				nxt_st.tx.status = 8'h50;
				nxt_st.tx.seccnt = 8'h01;
				nxt_st.tx.lbalo = 8'h01;
				nxt_st.state = DV_RUN;
			end
			DV_RUN: begin
				if (done_i && !nxt_st.tx_valid) begin
					nxt_st.tx_valid = 1'b1;
					nxt_st.tx = '0;
					nxt_st.tx.status = done_status_i;
					nxt_st.tx.error = done_error_i;
					nxt_st.tx.int_req = done_irq_i;
					nxt_st.busy = 1'b0;
				end
				if (!st_ff.att_sync[1] || link.comreset) begin
					nxt_st.state = DV_IDLE;
				end
			end
			default: nxt_st.state = DV_IDLE;
		endcase
	end
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_ff <= '0;
			st_ff.state <= DV_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule

// file: tb/stfe_sva.sv
/*
 * link assertions for the adapter and device pair.
 * assumes both ends on mclk_i with synchronous active-high rst_i.
 */
`timescale 1ns/100ps
module stfe_sva (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic present,
	input wire logic comreset,
	input wire logic h2d_valid,
	input wire logic h2d_ready,
	input stfe_pkg::stfe_frame_t h2d_frame,
	input wire logic d2h_valid,
	input wire logic d2h_ready,
	input stfe_pkg::stfe_frame_t d2h_frame
);
	logic tx_take;
	logic [11:0] sr_age_ff;
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	// =========================================================
	// helper: cycles since a set soft-reset frame left
	assign tx_take = h2d_valid && h2d_ready;
	always_ff @(posedge mclk_i) begin
		if (rst_i || (tx_take && !h2d_frame.devctl[stfe_pkg::DC_SOFT_RESET_POS]))
			sr_age_ff <= 12'h000;
		else if (tx_take)
			sr_age_ff <= 12'h001;
		else if (sr_age_ff != 12'h000)
			sr_age_ff <= sr_age_ff + 12'h001;
	end
	// =========================================================
	// assertions
	a_gate_drive_sel: assert property (h2d_valid |-> !h2d_frame.devhead[stfe_pkg::DH_DRIVE_SEL_POS])
		else $error("frame sent with drive one selected");
	a_no_tx_discovery: assert property (!present |-> !h2d_valid)
		else $error("frame sent before presence");
	a_quiet_after_reset: assert property ($fell(rst_i) |-> !h2d_valid [*3])
		else $error("frame right after reset");
	a_clear_frame_due: assert property (sr_age_ff < 12'h4b0)
		else $error("clearing soft reset frame missing");
	a_device_takes_all: assert property (h2d_valid |-> h2d_ready)
		else $error("device stalled a frame");
	a_d2h_taken: assert property (d2h_valid |-> d2h_ready)
		else $error("adapter refused a device frame");
	a_signature_due: assert property ($rose(present) |-> ##[0:4] d2h_valid)
		else $error("no signature frame after presence");
	a_comreset_pulse: assert property (comreset |=> !comreset)
		else $error("comreset longer than one cycle");
	// main scenarios seen
	cover property (tx_take && h2d_frame.devctl[stfe_pkg::DC_SOFT_RESET_POS]);
	cover property (d2h_valid && d2h_frame.int_req);
	cover property (comreset);
endmodule

// file: tb/test_shadow_taskfile_emulation.sv
/*
 * self-checking bench: adapter and device joined over the link.
 * assumes the design files and stfe_sva compiled before it.
 */
`timescale 1ns/100ps
module test_shadow_taskfile_emulation;
	typedef struct {
		string nm;
		logic [32:0] v;
	} stfe_note_t;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic intrq_o;
	logic attach_i = 1'b0;
	logic done_i = 1'b0;
	logic [7:0] done_status_i = 8'h00;
	logic [7:0] done_error_i = 8'h00;
	logic done_irq_i = 1'b0;
	logic rx_valid_o;
	logic [7:0] rx_command_o;
	logic rx_soft_reset_o;
	logic busy_o;
	logic watch_rx = 1'b0;
	int n_mismatch = 0;
	int total_checks = 0;
	stfe_note_t rdq[$];
	logic [32:0] rxq[$];
	stfe_link_if lk();
	stfe_adapter stfe_adapter_i (.mclk_i(mclk_i), .rst_i(rst_i), .link(lk), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .intrq_o(intrq_o), .comreset_o());
	stfe_device stfe_device_i (.mclk_i(mclk_i), .rst_i(rst_i), .link(lk), .attach_i(attach_i), .done_i(done_i),
		.done_status_i(done_status_i), .done_error_i(done_error_i), .done_irq_i(done_irq_i), .rx_valid_o(rx_valid_o),
		.rx_command_o(rx_command_o), .rx_soft_reset_o(rx_soft_reset_o), .busy_o(busy_o));
	stfe_sva stfe_sva_i (.mclk_i(mclk_i), .rst_i(rst_i), .present(lk.present), .comreset(lk.comreset),
		.h2d_valid(lk.h2d_valid), .h2d_ready(lk.h2d_ready), .h2d_frame(lk.h2d_frame), .d2h_valid(lk.d2h_valid),
		.d2h_ready(lk.d2h_ready), .d2h_frame(lk.d2h_frame));
	// 200 MHz clock
	initial forever #2.5 mclk_i = ~mclk_i;
	// =========================================================
	// helpers
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		total_checks++;
		if (e !== g) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	function automatic logic [11:0] ta(input logic [3:0] i);
		return {6'h00, i, 2'h0};
	endfunction
	// one apb transfer, held until pready
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge mclk_i);
		end while (pready_o !== 1'b1);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		bus(1'b1, a, {16'h0, d});
	endtask
	task automatic rd(input string nm, input logic [11:0] a, input logic [32:0] e);
		rdq.push_back('{nm, e});
		bus(1'b0, a, 32'h0);
	endtask
	task automatic end_cmd(input logic [7:0] s, input logic [7:0] e, input logic q);
		@(posedge mclk_i);
		done_status_i <= s;
		done_error_i <= e;
		done_irq_i <= q;
		done_i <= 1'b1;
		@(posedge mclk_i);
		done_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
	endtask
	task automatic irq_is(input logic e);
		repeat (3) @(posedge mclk_i);
		chk("intrq", 33'(e), 33'(intrq_o));
	endtask
	task automatic wait_rx;
		int n;
		n = 0;
		while (rxq.size() != 0 && n < 100) begin
			@(posedge mclk_i);
			n++;
		end
	endtask
	task automatic print_verdict;
		// any expected results never seen add one mismatch in all
		if (rdq.size() != 0 || rxq.size() != 0)
			n_mismatch++;
		$display("checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// =========================================================
	// monitors: read data and frames at the device
	always @(posedge mclk_i) begin
		stfe_note_t n;
		if (pready_o === 1'b1 && psel_i === 1'b1 && pwrite_i === 1'b0 && rdq.size() != 0) begin
			n = rdq.pop_front();
			chk(n.nm, n.v, {pslverr_o, n.v[32] ? n.v[31:0] : prdata_o});
		end
	end
	always @(posedge mclk_i) begin
		if (rx_valid_o === 1'b1 && watch_rx)
			chk("rx_frame", (rxq.size() != 0) ? rxq.pop_front() : 33'h1ffffffff,
				{24'h0, rx_command_o, rx_soft_reset_o});
	end
	// watchdog
	initial begin
		#100000;
		n_mismatch++;
		print_verdict;
	end
	// =========================================================
	// main sequence
	initial begin
		int i;
		logic [15:0] r;
		void'($urandom(90959));
		repeat (4) @(posedge mclk_i);
		rst_i <= 1'b0;
		for (i = 0; i <= 8; i++)
			rd("taskfile", ta(i[3:0]), (i == 0) ? 33'hffff : (i == 7) ? 33'h7f : 33'hff);
		wr(ta(stfe_pkg::TF_LBALO), 16'h0012);
		rd("lba_low", ta(stfe_pkg::TF_LBALO), 33'hff);
		// attach, then bring the shadow to known contents
		attach_i <= 1'b1;
		repeat (20) @(posedge mclk_i);
		wr(ta(stfe_pkg::TF_DEVHEAD), 16'h00a0);
		rd("device_head", ta(stfe_pkg::TF_DEVHEAD), 33'ha0);
		wr(ta(stfe_pkg::TF_DEVCTL), 16'h0000);
		end_cmd(8'h50, 8'h00, 1'b0);
		rd("status", ta(stfe_pkg::TF_STATCMD), 33'h50);
		watch_rx <= 1'b1;
		// command write with drive zero
		rxq.push_back({24'h0, 8'h25, 1'b0});
		wr(ta(stfe_pkg::TF_STATCMD), 16'h0025);
		rd("status", ta(stfe_pkg::TF_STATCMD), 33'hd0);
		wait_rx;
		chk("device_busy", 33'h1, {32'h0, busy_o});
		// interrupt set, gated and cleared
		end_cmd(8'h50, 8'h04, 1'b1);
		irq_is(1'b1);
		wr(ta(stfe_pkg::TF_DEVHEAD), 16'h0010);
		irq_is(1'b0);
		wr(ta(stfe_pkg::TF_DEVHEAD), 16'h0000);
		irq_is(1'b1);
		rd("error", ta(stfe_pkg::TF_ERROR), 33'h04);
		rd("status", ta(stfe_pkg::TF_STATCMD), 33'h50);
		irq_is(1'b0);
		wr(ta(stfe_pkg::TF_DEVCTL), 16'h0002);
		rd("status", ta(stfe_pkg::TF_STATCMD), 33'h50);
		end_cmd(8'h50, 8'h00, 1'b1);
		irq_is(1'b0);
		// drive one selected: no busy, no frame
		wr(ta(stfe_pkg::TF_DEVHEAD), 16'h0010);
		wr(ta(stfe_pkg::TF_STATCMD), 16'h0025);
		wr(ta(stfe_pkg::TF_DEVHEAD), 16'h0000);
		rd("status", ta(stfe_pkg::TF_STATCMD), 33'h50);
		// soft reset toggle at the shortest hold
		rxq.push_back({24'h0, 8'h25, 1'b1});
		rxq.push_back({24'h0, 8'h25, 1'b0});
		wr(ta(stfe_pkg::TF_DEVCTL), 16'h0004);
		rd("status", ta(stfe_pkg::TF_STATCMD), 33'hd0);
		repeat (stfe_pkg::SOFT_RESET_HOLD_CYC) @(posedge mclk_i);
		wr(ta(stfe_pkg::TF_DEVCTL), 16'h0000);
		wait_rx;
		// random read-back of plain registers, then an unmapped place
		for (i = 0; i <= 5; i += (i == 0) ? 2 : 1) begin
			r = 16'($urandom);
			wr(ta(i[3:0]), r);
			rd("taskfile", ta(i[3:0]), (i == 0) ? {17'h0, r} : {25'h0, r[7:0]});
		end
		rd("unmapped", stfe_pkg::APB_TXFR0, 33'h100000000);
		// comreset drops the pending interrupt
		end_cmd(8'h50, 8'h00, 1'b1);
		irq_is(1'b1);
		bus(1'b1, stfe_pkg::APB_CTRL, 32'h1);
		irq_is(1'b0);
		repeat (10) @(posedge mclk_i);
		print_verdict;
	end
endmodule
